// ===== hdl/wwdt_core.sv
// windowed watchdog timer: counter, window check, refresh register, interval interrupt
`timescale 1ns/1ps

// What this block does
// (RULE1) enabled option makes counting start by itself after reset release
// (RULE2) disabled option keeps the counter stopped after reset release
// (RULE3) writing key ACH clears the counter and restarts counting
// (RULE4) a write during the closed window requests reset, except the first write
// (RULE5) reaching overflow time without valid key requests reset
// (RULE6) a single-bit access to the refresh register requests reset
// (RULE7) writing any byte other than ACH requests reset
// (RULE8) the first write after reset clears the counter ignoring the window
// (RULE9) the clear takes effect within two low-speed clock cycles
// (RULE10) a valid key just before overflow still clears and avoids reset
// (RULE11) standby-run 0 halts counting in HALT, STOP, SNOOZE; 1 keeps counting
// (RULE12) standby-run 0: leaving HALT or STOP clears counter and resumes
// (RULE13) overflow select codes give 2^6,7,8,9,11,13,14,16 low-speed cycles
// (RULE14) window code 01 opens last half, code 11 opens the whole period
// (RULE15) standby-run 0 forces the window open for the whole period
// (RULE16) interval interrupt at 75 percent of overflow plus half a cycle
// (RULE17) interval interrupt neither stops nor clears the counter
// (RULE18) software masks, clears counter, waits 80 us, clears flag, unmasks
// (RULE19) counter is 17 bits and counts low-speed oscillator cycles
// (RULE20) refresh register reads 9AH when enabled, 1AH when disabled
// (RULE21) a watchdog reset raises the watchdog reset cause toward the controller
// (RULE22) option settings are loaded at reset and then stay static
module wwdt_core
    import wwdt_pkg::*;
#(
    parameter int CNT_W = WWDT_CNT_W
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic fil_clk,
    input wire wwdt_opt_t opt_in,
    input wire wwdt_mode_t mode_in,
    input wire wwdt_bus_t bus_in,
    output logic [WWDT_DATA_W-1:0] rd_data,
    output logic wdt_reset_req,
    output logic interval_interrupt,
    output logic count_active
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        WWDT_ST_LOAD,
        WWDT_ST_RUN,
        WWDT_ST_FAULT
    } wwdt_state_t;

    wwdt_state_t state_r;
    wwdt_state_t state_nxt;

    wwdt_opt_t opt_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic pend_r;
    logic pend_nxt;
    logic first_done_r;
    logic irq_done_r;
    logic stby_prev_r;
    logic fil_s1_r;
    logic fil_s2_r;
    logic fil_s3_r;
    logic [WWDT_DATA_W-1:0] rd_data_r;
    logic reset_req_r;
    logic irq_r;
    logic active_r;

    // ------------------------------------------------------------------
    // low-speed clock sampling
    // ------------------------------------------------------------------
    // fil_s1_r feeds only fil_s2_r; edges are taken from the later stages
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fil_s1_r <= 1'b0;
            fil_s2_r <= 1'b0;
            fil_s3_r <= 1'b0;
        end
        else
        begin
            fil_s1_r <= fil_clk;
            fil_s2_r <= fil_s1_r;
            fil_s3_r <= fil_s2_r;
        end
    end

    wire fil_rise = fil_s2_r & ~fil_s3_r;
    wire fil_fall = ~fil_s2_r & fil_s3_r;

    // ------------------------------------------------------------------
    // option derived settings
    // ------------------------------------------------------------------
    wire [2:0] ovf_sel = {opt_r.overflow_select_bit2, opt_r.overflow_select_bit1,
                          opt_r.overflow_select_bit0};
    wire [1:0] win_sel = {opt_r.window_select_bit1, opt_r.window_select_bit0};

    // sizes the wrap point from the option code
    wire [CNT_W-1:0] ovf_limit = CNT_W'(wwdt_ovf_limit(ovf_sel)); // RULE13
    wire [CNT_W-1:0] ovf_last = ovf_limit - CNT_W'(1);
    wire [CNT_W-1:0] win_open_at = ovf_limit >> 1;
    // three quarters of the period; reached on the falling edge for the half cycle
    wire [CNT_W-1:0] irq_point = (ovf_limit >> 1) + (ovf_limit >> 2);

    wire enabled = opt_r.counter_enable_option;
    wire standby_run = opt_r.standby_run_option;
    // prohibited window codes are treated as fully open
    wire half_window = standby_run & (win_sel == WWDT_WIN_HALF); // RULE14 RULE15
    wire window_closed = half_window & (cnt_r < win_open_at); // RULE14

    // ------------------------------------------------------------------
    // standby handling
    // ------------------------------------------------------------------
    wire in_standby = mode_in.halt | mode_in.stop | mode_in.snooze;
    wire halt_or_stop = mode_in.halt | mode_in.stop;
    wire paused = ~standby_run & in_standby; // RULE11
    wire standby_exit = ~standby_run & stby_prev_r & ~halt_or_stop; // RULE12

    // ------------------------------------------------------------------
    // refresh register decode
    // ------------------------------------------------------------------
    wire running = (state_r == WWDT_ST_RUN);
    wire hit = (bus_in.addr == WWDT_REFRESH_OFS);
    wire ref_wr = running & bus_in.wr & hit;
    wire ref_rd = bus_in.rd & hit;
    wire bad_bitop = ref_wr & bus_in.bitop; // RULE6
    wire bad_key = ref_wr & (bus_in.wdata != WWDT_KEY); // RULE7
    // the first write after reset is allowed anywhere before overflow
    wire bad_window = ref_wr & enabled & first_done_r & window_closed; // RULE4 RULE8
    wire wr_fault = bad_bitop | bad_key | bad_window;
    wire key_ok = ref_wr & ~wr_fault; // RULE3

    wire [WWDT_DATA_W-1:0] rd_value = enabled ? WWDT_RD_ENABLED : WWDT_RD_DISABLED; // RULE20
    wire [WWDT_DATA_W-1:0] rd_data_nxt = ref_rd ? rd_value : WWDT_RD_UNMAPPED;

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    // a key is held pending until the next low-speed edge, so the clear lands
    // within the sampler latency plus one low-speed cycle
    wire clear_now = fil_rise & (pend_r | key_ok); // RULE9
    wire counting = running & enabled & ~paused; // RULE1 RULE2 RULE11
    wire tick = counting & fil_rise;
    // a pending clear beats the wrap in the same edge
    wire overflow = tick & ~clear_now & (cnt_r == ovf_last); // RULE5 RULE10
    wire irq_hit = counting & fil_fall & opt_r.interval_irq_option & ~irq_done_r
                   & (cnt_r == irq_point); // RULE16

    always_comb
    begin
        cnt_nxt = cnt_r;
        pend_nxt = pend_r;
        if (key_ok)
        begin
            pend_nxt = 1'b1; // RULE3
        end
        if (!running || !enabled)
        begin
            cnt_nxt = WWDT_CNT_RST; // RULE2
            pend_nxt = 1'b0;
        end
        else if (standby_exit)
        begin
            cnt_nxt = WWDT_CNT_RST; // RULE12
            pend_nxt = 1'b0;
        end
        else if (clear_now && !paused)
        begin
            cnt_nxt = WWDT_CNT_RST; // RULE9 RULE10
            pend_nxt = 1'b0;
        end
        else if (tick)
        begin
            // the interval interrupt does not touch the count
            cnt_nxt = cnt_r + CNT_W'(1); // RULE17 RULE19
        end
    end

    // ------------------------------------------------------------------
    // control state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            WWDT_ST_LOAD:
            begin
                state_nxt = WWDT_ST_RUN; // RULE1
            end
            WWDT_ST_RUN:
            begin
                if (wr_fault || overflow)
                begin
                    state_nxt = WWDT_ST_FAULT; // RULE4 RULE5 RULE6 RULE7
                end
            end
            WWDT_ST_FAULT:
            begin
                // held until the reset controller resets the chip
                state_nxt = WWDT_ST_FAULT;
            end
            // a corrupted state code is safest treated as a fault
            default:
            begin
                state_nxt = WWDT_ST_FAULT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= WWDT_ST_LOAD;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // options are captured once, in the first cycle after release
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            opt_r <= wwdt_opt_t'(WWDT_OPT_RST);
        end
        else if (state_r == WWDT_ST_LOAD)
        begin
            opt_r <= opt_in; // RULE22
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= WWDT_CNT_RST;
        end
        else
        begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pend_r <= 1'b0;
        end
        else
        begin
            pend_r <= pend_nxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            first_done_r <= 1'b0;
        end
        else if (ref_wr)
        begin
            first_done_r <= 1'b1; // RULE8
        end
    end

    // one interrupt per counter period; re-armed by any clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_done_r <= 1'b0;
        end
        else if (cnt_nxt == WWDT_CNT_RST)
        begin
            irq_done_r <= 1'b0;
        end
        else if (irq_hit)
        begin
            irq_done_r <= 1'b1; // RULE16
        end
    end

    // halt or stop level of the previous cycle, so the exit edge can be seen
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stby_prev_r <= 1'b0;
        end
        else
        begin
            stby_prev_r <= halt_or_stop;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_data_r <= WWDT_RD_UNMAPPED;
            active_r <= 1'b0;
        end
        else
        begin
            rd_data_r <= rd_data_nxt; // RULE20
            active_r <= counting;
        end
    end

    // the request follows the fault state, so it stays high until the chip reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reset_req_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            reset_req_r <= (state_nxt == WWDT_ST_FAULT); // RULE21
            irq_r <= irq_hit; // RULE16
        end
    end

    assign rd_data = rd_data_r;
    assign wdt_reset_req = reset_req_r;
    assign interval_interrupt = irq_r;
    assign count_active = active_r;

endmodule : wwdt_core

// ===== hdl/wwdt_pkg.sv
// shared constants, option layout and bus carrier of the windowed watchdog
package wwdt_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int WWDT_CNT_W = 17;
    localparam int WWDT_DATA_W = 8;
    localparam int WWDT_ADDR_W = 4;

    // ------------------------------------------------------------------
    // register map and values
    // ------------------------------------------------------------------
    localparam logic [WWDT_ADDR_W-1:0] WWDT_REFRESH_OFS = 4'h0;
    localparam logic [WWDT_DATA_W-1:0] WWDT_KEY = 8'h00AC;
    localparam logic [WWDT_DATA_W-1:0] WWDT_RD_ENABLED = 8'h009A;
    localparam logic [WWDT_DATA_W-1:0] WWDT_RD_DISABLED = 8'h001A;
    localparam logic [WWDT_DATA_W-1:0] WWDT_RD_UNMAPPED = 8'h0000;
    localparam logic [WWDT_DATA_W-1:0] WWDT_OPT_RST = 8'h0000;
    localparam logic [WWDT_CNT_W-1:0] WWDT_CNT_RST = 17'h0_0000;
    localparam logic [1:0] WWDT_WIN_HALF = 2'b01;

    // ------------------------------------------------------------------
    // overflow times in low-speed clock cycles
    // ------------------------------------------------------------------
    localparam logic [WWDT_CNT_W-1:0] WWDT_OVF_0 = 17'h0_0040;
    localparam logic [WWDT_CNT_W-1:0] WWDT_OVF_1 = 17'h0_0080;
    localparam logic [WWDT_CNT_W-1:0] WWDT_OVF_2 = 17'h0_0100;
    localparam logic [WWDT_CNT_W-1:0] WWDT_OVF_3 = 17'h0_0200;
    localparam logic [WWDT_CNT_W-1:0] WWDT_OVF_4 = 17'h0_0800;
    localparam logic [WWDT_CNT_W-1:0] WWDT_OVF_5 = 17'h0_2000;
    localparam logic [WWDT_CNT_W-1:0] WWDT_OVF_6 = 17'h0_4000;
    localparam logic [WWDT_CNT_W-1:0] WWDT_OVF_7 = 17'h1_0000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic interval_irq_option;
        logic window_select_bit1;
        logic window_select_bit0;
        logic counter_enable_option;
        logic overflow_select_bit2;
        logic overflow_select_bit1;
        logic overflow_select_bit0;
        logic standby_run_option;
    } wwdt_opt_t;

    typedef struct packed {
        logic halt;
        logic stop;
        logic snooze;
    } wwdt_mode_t;

    typedef struct packed {
        logic [WWDT_ADDR_W-1:0] addr;
        logic [WWDT_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
        logic bitop;
    } wwdt_bus_t;

    function automatic logic [WWDT_CNT_W-1:0] wwdt_ovf_limit(input logic [2:0] sel);
        logic [WWDT_CNT_W-1:0] lim;
        lim = WWDT_OVF_0;
        unique case (sel)
            3'h0: lim = WWDT_OVF_0;
            3'h1: lim = WWDT_OVF_1;
            3'h2: lim = WWDT_OVF_2;
            3'h3: lim = WWDT_OVF_3;
            3'h4: lim = WWDT_OVF_4;
            3'h5: lim = WWDT_OVF_5;
            3'h6: lim = WWDT_OVF_6;
            3'h7: lim = WWDT_OVF_7;
        endcase
        return lim;
    endfunction : wwdt_ovf_limit

endpackage : wwdt_pkg

// ===== test/tb_wwdt_core.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
module tb_wwdt_core;
    import wwdt_pkg::*;
    logic clk;
    logic arst_n;
    logic fil_clk;
    wwdt_opt_t opt_in;
    wwdt_mode_t mode_in;
    wwdt_bus_t bus_in;
    logic [WWDT_DATA_W-1:0] rd_data;
    logic wdt_reset_req;
    logic interval_interrupt;
    logic count_active;
    logic cause_flag;
    logic [7:0] irq_cnt;
    logic irq_flag;
    logic irq_mask;
    logic flag_clr;
    int n_mismatch = 0;
    int checked = 0;
    int lim [5] = '{64, 128, 256, 512, 2048};
    int t;
    int t_irq;
    wwdt_core uut (.clk(clk), .arst_n(arst_n), .fil_clk(fil_clk), .opt_in(opt_in),
        .mode_in(mode_in), .bus_in(bus_in), .rd_data(rd_data), .wdt_reset_req(wdt_reset_req),
        .interval_interrupt(interval_interrupt), .count_active(count_active));
    wwdt_far_model far (.clk(clk), .arst_n(arst_n), .wdt_reset_req(wdt_reset_req),
        .interval_interrupt(interval_interrupt), .irq_mask(irq_mask), .flag_clr(flag_clr),
        .fil_clk(fil_clk), .cause_flag(cause_flag), .irq_flag(irq_flag), .irq_cnt(irq_cnt));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("mismatches %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic boot(input wwdt_opt_t o, input wwdt_mode_t m);
        arst_n <= 1'b0;
        opt_in <= o;
        mode_in <= m;
        bus_in <= '0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
    endtask : boot
    task automatic op(input logic r, input logic w, input logic [3:0] a,
        input logic [7:0] d, input logic b);
        bus_in <= '{addr: a, wdata: d, wr: w, rd: r, bitop: b};
        @(posedge clk);
    endtask : op
    // leaves the bench 1 ns past the edge so outputs have settled
    task automatic idle(input int n);
        bus_in <= '0;
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        op(1'b1, 1'b0, a, 8'h00, 1'b0);
        #1;
        chk("rd_data", exp, rd_data);
        idle(1);
    endtask : rd_chk
    task automatic wait_req(input int lo, input int hi);
        t = 0;
        t_irq = 0;
        while (wdt_reset_req !== 1'b1 && t < hi)
        begin
            idle(1);
            t++;
            if (interval_interrupt === 1'b1 && t_irq == 0)
                t_irq = t;
        end
        if (t >= hi)
        begin
            n_mismatch++;
            $display("[ERR] reset request expected 1 seen 0");
            report_and_stop();
        end
        else
            chk("reset time", 1, t >= lo);
    endtask : wait_req
    initial
    begin
        arst_n = 1'b0;
        opt_in = '0;
        mode_in = '0;
        bus_in = '0;
        irq_mask = 1'b0;
        flag_clr = 1'b0;
        @(posedge clk);
        boot(8'h60, 3'h0);
        rd_chk(4'h0, WWDT_RD_DISABLED);
        op(1'b0, 1'b1, 4'h1, 8'h55, 1'b0);
        rd_chk(4'h1, WWDT_RD_UNMAPPED);
        idle(400);
        chk("idle req", 0, wdt_reset_req);
        chk("idle count", 0, count_active);
        op(1'b0, 1'b1, 4'h0, 8'h55, 1'b0);
        idle(1);
        chk("wrong key", 1, wdt_reset_req);
        boot(8'h70, 3'h0);
        rd_chk(4'h0, WWDT_RD_ENABLED);
        op(1'b0, 1'b1, 4'h0, WWDT_KEY, 1'b1);
        idle(1);
        chk("bit access", 1, wdt_reset_req);
        for (int c = 0; c < 5; c++)
        begin
            boot({4'hF, c[2:0], 1'b0}, 3'h0);
            wait_req(lim[c] * 4 - 4, lim[c] * 4 + 16);
            chk("irq time", 1, t_irq >= 3 * lim[c] - 2 && t_irq <= 3 * lim[c] + 14);
            chk("irq count", 1, irq_cnt);
            idle(1);
            chk("cause flag", 1, cause_flag);
        end
        // half window selected but standby-run 0 keeps it fully open
        boot(8'h30, 3'h0);
        for (int i = 0; i < 4; i++)
        begin
            idle(100);
            op(1'b0, 1'b1, 4'h0, WWDT_KEY, 1'b0);
        end
        idle(236);
        op(1'b0, 1'b1, 4'h0, WWDT_KEY, 1'b0);
        idle(200);
        chk("refresh kept", 0, wdt_reset_req);
        wait_req(1, 120);
        boot(8'h70, 3'h0);
        idle(150);
        mode_in <= 3'b100;
        idle(600);
        chk("halted", 0, wdt_reset_req);
        mode_in <= 3'b000;
        idle(200);
        chk("halt exit clear", 0, wdt_reset_req);
        wait_req(20, 100);
        // snooze freezes the count but leaving it does not clear the count
        boot(8'h70, 3'h0);
        idle(150);
        mode_in <= 3'b001;
        idle(600);
        chk("snoozed", 0, wdt_reset_req);
        mode_in <= 3'b000;
        wait_req(95, 115);
        boot(8'h71, 3'b011);
        wait_req(252, 272);
        boot(8'h31, 3'h0);
        idle(20);
        op(1'b0, 1'b1, 4'h0, WWDT_KEY, 1'b0);
        idle(1);
        chk("first write", 0, wdt_reset_req);
        op(1'b0, 1'b1, 4'h0, WWDT_KEY, 1'b0);
        idle(1);
        chk("closed window", 1, wdt_reset_req);
        // interval interrupt serviced as software must: mask, refresh, wait, clear, unmask
        boot(8'hF8, 3'h0);
        t = 0;
        while (irq_flag !== 1'b1 && t < 7000)
        begin
            idle(1);
            t++;
        end
        chk("irq flag", 1, irq_flag);
        if (irq_flag !== 1'b1)
            report_and_stop();
        irq_mask <= 1'b1;
        op(1'b0, 1'b1, 4'h0, WWDT_KEY, 1'b0);
        idle(3210);
        flag_clr <= 1'b1;
        idle(1);
        flag_clr <= 1'b0;
        irq_mask <= 1'b0;
        idle(2);
        chk("flag cleared", 0, irq_flag);
        chk("masked irq count", 1, irq_cnt);
        chk("counter alive", 0, wdt_reset_req);
        report_and_stop();
    end
endmodule : tb_wwdt_core
bind wwdt_core wwdt_core_props #(.CNT_W(CNT_W)) u_props (.clk(clk), .arst_n(arst_n),
    .fil_clk(fil_clk), .opt_in(opt_in), .mode_in(mode_in), .bus_in(bus_in),
    .rd_data(rd_data), .wdt_reset_req(wdt_reset_req),
    .interval_interrupt(interval_interrupt), .count_active(count_active));

// ===== test/wwdt_core_props.sv
// port-level assertion checker for the windowed watchdog
`timescale 1ns/1ps
module wwdt_core_props
    import wwdt_pkg::*;
#(
    parameter int CNT_W = WWDT_CNT_W
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic fil_clk,
    input wire wwdt_opt_t opt_in,
    input wire wwdt_mode_t mode_in,
    input wire wwdt_bus_t bus_in,
    input wire logic [WWDT_DATA_W-1:0] rd_data,
    input wire logic wdt_reset_req,
    input wire logic interval_interrupt,
    input wire logic count_active
);
    // writes in the option load cycle are ignored, so gate on this
    logic up_r;
    logic hit;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            up_r <= 1'b0;
        else
            up_r <= 1'b1;
    end
    assign hit = up_r && bus_in.addr == WWDT_REFRESH_OFS;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_bad_key;
        hit && bus_in.wr && bus_in.wdata != WWDT_KEY;
    endsequence
    sequence s_bit_wr;
        hit && bus_in.wr && bus_in.bitop;
    endsequence
    a_bad_key: assert property (s_bad_key |=> wdt_reset_req)
        else $error("wrong key gave no reset request");
    a_bit_access: assert property (s_bit_wr |=> wdt_reset_req)
        else $error("bit access gave no reset request");
    a_read_value: assert property (hit && bus_in.rd |=> rd_data ==
        (opt_in.counter_enable_option ? WWDT_RD_ENABLED : WWDT_RD_DISABLED))
        else $error("refresh read value wrong");
    a_read_unmapped: assert property (bus_in.rd && !hit |=> rd_data == WWDT_RD_UNMAPPED)
        else $error("unmapped read not zero");
    a_req_sticks: assert property (wdt_reset_req |=> wdt_reset_req)
        else $error("reset request dropped");
    a_irq_pulse: assert property (interval_interrupt |=> !interval_interrupt)
        else $error("interval interrupt longer than one cycle");
    a_irq_off: assert property (!opt_in.interval_irq_option |-> !interval_interrupt)
        else $error("interval interrupt while disabled");
    a_stays_off: assert property (!opt_in.counter_enable_option |-> !count_active)
        else $error("counter runs while disabled");
    a_auto_start: assert property ($rose(up_r) && opt_in.counter_enable_option
        && mode_in == 3'b000 |-> ##[1:3] count_active)
        else $error("counter did not start after reset");
endmodule : wwdt_core_props

// ===== test/wwdt_far_model.sv
// oscillator, reset controller and interrupt controller stand-in
`timescale 1ns/1ps
module wwdt_far_model
#(
    parameter int HALF_NS = 50
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wdt_reset_req,
    input wire logic interval_interrupt,
    input wire logic irq_mask,
    input wire logic flag_clr,
    output logic fil_clk,
    output logic cause_flag,
    output logic irq_flag,
    output logic [7:0] irq_cnt
);
    // the oscillator runs free, phase unrelated to clk
    initial
    begin
        fil_clk = 1'b0;
        #7;
        forever #(HALF_NS) fil_clk = ~fil_clk;
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cause_flag <= 1'b0;
            irq_flag <= 1'b0;
            irq_cnt <= 8'h00;
        end
        else
        begin
            cause_flag <= cause_flag | wdt_reset_req;
            // a new request beats a clear in the same cycle
            irq_flag <= interval_interrupt | (irq_flag & ~flag_clr);
            irq_cnt <= irq_cnt + 8'(interval_interrupt & ~irq_mask);
        end
    end
endmodule : wwdt_far_model
